// ===== design/asc_map.vh
// register map, field positions, reset values and timing counts of the
// converter sequencer; definitions only, included by every design file
`ifndef ASC_MAP_VH
`define ASC_MAP_VH

// byte offsets on the peripheral bus
`define ASC_OFF_CONTROL      8'h00
`define ASC_OFF_MODE         8'h04
`define ASC_OFF_CHAN_SET     8'h10
`define ASC_OFF_CHAN_CLR     8'h14
`define ASC_OFF_CHAN_STATE   8'h18
`define ASC_OFF_STATUS       8'h1c
`define ASC_OFF_LAST_RESULT  8'h20
`define ASC_OFF_IRQ_SET      8'h24
`define ASC_OFF_IRQ_CLR      8'h28
`define ASC_OFF_IRQ_MASK     8'h2c
`define ASC_OFF_CHAN0_RESULT 8'h30
`define ASC_OFF_CHAN7_RESULT 8'h4c
`define ASC_OFF_REVISION     8'hfc

// control bits
`define ASC_CR_SOFT_RESET    0
`define ASC_CR_START         1

// mode_config fields
`define ASC_MR_TRIG_EN       0
`define ASC_MR_TRIG_SEL_LO   1
`define ASC_MR_LOW_RES       4
`define ASC_MR_SLEEP         5
`define ASC_MR_DIV_LO        8
`define ASC_MR_WARM_LO       16
`define ASC_MR_SH_LO         24
`define ASC_MR_MASK          32'h0f7fff3f
`define ASC_MR_RESET         32'h00000000

// status_flags fields
`define ASC_SR_OVR_LO        8
`define ASC_SR_RDY           16
`define ASC_SR_GOVR          17
`define ASC_SR_DMA_END       18
`define ASC_SR_DMA_FULL      19
`define ASC_SR_RESET         32'h000c0000

// timing: converter clock periods per conversion, warmup multiplier
`define ASC_CONV_TICKS       10'h00a
`define ASC_WARM_MULT        3
`define ASC_EXT_TRIG_CODE    3'h6

// module revision, value arbitrary
`define ASC_REVISION         32'h00000101

`endif

// ===== design/asc_clock_div.v
// converter clock divider: period is 2*(divider+1) bus clocks
// assumes divider and restart come from logic on pclk
`include "asc_map.vh"

module asc_clock_div (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       restart,
   input  wire [7:0] divider,
   output reg        conv_clk,
   output reg        tick
);

   reg [7:0] count;

   ////////////////////////////////////////////////////////////////////////
   // toggle every divider+1 cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count    <= 8'h00;
         conv_clk <= 1'b1;
      end else if (restart) begin
         count    <= 8'h00;      // high now, next rise one full period away
         conv_clk <= 1'b1;
      end else if (count == divider) begin
         count    <= 8'h00;
         conv_clk <= ~conv_clk;  // R5
      end else begin
         count    <= count + 8'h01;
      end
   end

   // tick: converter clock rises at the coming pclk edge
   always @* begin
      tick = (count == divider) && !conv_clk && !restart;
   end

endmodule

// ===== design/asc_trigger.v
// hardware trigger selection: six timer outputs and one external input,
// each synchronised, then a rising edge of the chosen one makes a pulse
// assumes all trigger inputs are asynchronous to pclk
`include "asc_map.vh"

module asc_trigger (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       clear,
   input  wire [6:0] trig_in,
   input  wire [2:0] select,
   input  wire       enable,
   output reg        start
);

   reg  [6:0] meta;
   reg  [6:0] sync;
   reg        last;
   wire       level;

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchroniser per trigger line
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : gen_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta[g] <= 1'b0;
               sync[g] <= 1'b0;
            end else begin
               meta[g] <= trig_in[g];
               sync[g] <= meta[g];
            end
         end
      end
   endgenerate

   // codes 0..5 timers, 6 external, 7 none
   assign level = (select == 3'h7) ? 1'b0 : sync[select];  // R8

   ////////////////////////////////////////////////////////////////////////
   // rising edge detect, gated by the enable bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last  <= 1'b0;
         start <= 1'b0;
      end else if (clear) begin
         last  <= 1'b0;
         start <= 1'b0;
      end else begin
         last  <= level;
         start <= enable & level & ~last;  // R9 R22
      end
   end

endmodule

// ===== design/asc_top.v
// eight-channel converter sequencer with its register file on apb
// assumes an apb master on pclk, an analog cell that presents a stable
// ten-bit result on cell_data by the end of the conversion phase, and
// trigger and dma status lines asynchronous to pclk
//
// Register access over APB was decided locally.
`include "asc_map.vh"

// Contract
// R1: writing one to start launches a sequence; zero ignored; reads zero
// R2: writing one to soft reset resets the controller; zero ignored; reads zero
// R3: sample-and-hold lasts sample-hold field plus one converter clock periods
// R4: startup wait lasts warmup field plus one, times eight, converter periods
// R5: converter clock is bus clock divided by two times divider plus one
// R6: sleep bit one selects sleep operation; zero keeps analog cell active
// R7: resolution bit one gives 8-bit results, zero gives 10-bit results
// R8: trigger select codes 0-5 pick timer triggers, 6 the external trigger
// R9: trigger enable one accepts hardware triggers; zero allows software only
// R10: ones written to channel enable set register enable channels; reads zero
// R11: ones written to channel enable clear register disable channels; reads zero
// R12: channel state bit reads one while its channel is enabled
// R13: software must not toggle a channel during a conversion
// R14: dma buffer full flag follows the dma buffer full signal
// R15: dma receive end flag follows the dma end of receive signal
// R16: global overrun sets on general overrun, clears on status read
// R17: result ready sets on new last result, clears on last result read
// R18: channel overrun flags set on channel overrun, clear on status read
// R19: channel done sets on completion, clears on its result or last read
// R20: last result holds latest ten-bit result until the next completes
// R21: one start converts every enabled channel in turn, then idles
// R22: hardware start on each rising edge; software starts still work
// R23: sleep start powers cell, waits startup, powers down after; ignores triggers; the code still launches on hardware triggers in sleep mode
// R24: overrun when data arrives unread; global overrun when ready still set
// R25: soft reset returns all registers and sequencer to reset values
module asc_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [5:0]  timer_output_a,
   input  wire        ext_trigger,
   input  wire        dma_buffer_full_in,
   input  wire        dma_receive_end_in,
   input  wire [9:0]  cell_data,
   output wire        cell_clk,
   output reg         cell_power,
   output reg  [2:0]  cell_channel,
   output reg         cell_sample,
   output reg         cell_convert,
   output reg         dma_req
);

   localparam [3:0] ST_IDLE   = 4'b0001;
   localparam [3:0] ST_WARM   = 4'b0010;
   localparam [3:0] ST_SAMPLE = 4'b0100;
   localparam [3:0] ST_CONV   = 4'b1000;

   reg  [3:0]  state;
   reg  [9:0]  count;
   reg  [2:0]  cur_chan;
   reg  [2:0]  last_chan;
   reg         soft_rst;
   reg  [31:0] mode_config;
   reg  [7:0]  channel_enable_state;
   reg  [7:0]  channel_done;
   reg  [7:0]  channel_overrun;
   reg         global_overrun;
   reg         result_ready;
   reg  [9:0]  last_result_value;
   reg  [9:0]  channel_result [0:7];
   reg  [31:0] irq_mask_state;
   reg  [9:0]  data_meta;
   reg  [9:0]  data_sync;
   reg  [1:0]  dma_meta;
   reg  [1:0]  dma_sync;
   reg  [31:0] rd_data;
   reg         rd_err;
   reg  [2:0]  next_chan;
   reg         next_found;
   reg  [3:0]  scan;
   reg  [3:0]  scan_base;
   wire        tick;
   wire        trig_start;
   wire        access;
   wire        wr;
   wire        rd;
   wire        in_result;
   wire [2:0]  result_idx;
   wire        sw_start;
   wire        launch;
   wire        capture;
   wire [9:0]  new_result;
   wire [7:0]  done_set;
   wire [7:0]  done_clr;
   wire [7:0]  ovr_clr;
   wire [9:0]  sh_load;
   wire [9:0]  warm_load;

   // mode_config field views
   wire        hw_trigger_enable  = mode_config[`ASC_MR_TRIG_EN];
   wire [2:0]  hw_trigger_select  = mode_config[`ASC_MR_TRIG_SEL_LO +: 3];
   wire        low_resolution_sel = mode_config[`ASC_MR_LOW_RES];
   wire        sleep_sel          = mode_config[`ASC_MR_SLEEP];
   wire [7:0]  clock_divider_sel  = mode_config[`ASC_MR_DIV_LO +: 8];
   wire [6:0]  warmup_cycles      = mode_config[`ASC_MR_WARM_LO +: 7];
   wire [3:0]  sample_hold_cycles = mode_config[`ASC_MR_SH_LO +: 4];

   ////////////////////////////////////////////////////////////////////////
   // bus decode: one access cycle, side effects at the completing edge
   assign access     = psel & penable & pready;
   assign wr         = access & pwrite;
   assign rd         = access & ~pwrite;
   assign in_result  = (paddr >= `ASC_OFF_CHAN0_RESULT) &&
                       (paddr <= `ASC_OFF_CHAN7_RESULT) && (paddr[1:0] == 2'b00);
   assign result_idx = paddr[4:2] - 3'h4;  // 0x30 maps to index 0
   assign sw_start   = wr && (paddr == `ASC_OFF_CONTROL) && pwdata[`ASC_CR_START];  // R1

   ////////////////////////////////////////////////////////////////////////
   // submodules: converter clock and hardware trigger
   asc_clock_div u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .restart  (launch | soft_rst),
      .divider  (clock_divider_sel),
      .conv_clk (cell_clk),
      .tick     (tick)
   );

   asc_trigger u_trig (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (soft_rst),
      .trig_in  ({ext_trigger, timer_output_a}),
      .select   (hw_trigger_select),
      .enable   (hw_trigger_enable),
      .start    (trig_start)
   );

   ////////////////////////////////////////////////////////////////////////
   // synchronisers for the cell result and the dma status lines
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_meta <= 10'h000;
         data_sync <= 10'h000;
         dma_meta  <= 2'b11;
         dma_sync  <= 2'b11;
      end else begin
         data_meta <= cell_data;
         data_sync <= data_meta;
         dma_meta  <= {dma_buffer_full_in, dma_receive_end_in};
         dma_sync  <= dma_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lowest enabled channel at or above the scan base
   always @* begin
      scan_base  = (state == ST_IDLE) ? 4'h0 : {1'b0, cur_chan} + 4'h1;
      next_found = 1'b0;
      next_chan  = 3'h0;
      for (scan = 4'h0; scan < 4'h8; scan = scan + 4'h1) begin
         if (!next_found && channel_enable_state[scan[2:0]] && scan >= scan_base) begin
            next_found = 1'b1;
            next_chan  = scan[2:0];
         end
      end
   end

   // timing loads, one less than the period count
   assign sh_load    = {6'h00, sample_hold_cycles};                           // R3
   assign warm_load  = {warmup_cycles, 3'b111};                               // R4
   assign launch     = (state == ST_IDLE) && (sw_start | trig_start) && next_found;
   assign capture    = (state == ST_CONV) && tick && (count == 10'h000);
   assign new_result = low_resolution_sel ? {2'b00, data_sync[9:2]} : data_sync;  // R7

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= ST_IDLE;
         count      <= 10'h000;
         cur_chan   <= 3'h0;
         cell_power <= 1'b0;
      end else if (soft_rst) begin
         state      <= ST_IDLE;  // R25
         count      <= 10'h000;
         cur_chan   <= 3'h0;
         cell_power <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               cell_power <= ~sleep_sel;  // R6
               if (launch) begin  // R21 R22
                  cur_chan   <= next_chan;
                  cell_power <= 1'b1;
                  if (sleep_sel) begin
                     state <= ST_WARM;  // R23
                     count <= warm_load;
                  end else begin
                     state <= ST_SAMPLE;
                     count <= sh_load;
                  end
               end
            end
            ST_WARM: begin
               if (tick) begin
                  if (count == 10'h000) begin
                     state <= ST_SAMPLE;
                     count <= sh_load;
                  end else begin
                     count <= count - 10'h001;
                  end
               end
            end
            ST_SAMPLE: begin
               if (tick) begin
                  if (count == 10'h000) begin
                     state <= ST_CONV;
                     count <= `ASC_CONV_TICKS - 10'h001;
                  end else begin
                     count <= count - 10'h001;
                  end
               end
            end
            ST_CONV: begin
               if (tick) begin
                  if (count != 10'h000) begin
                     count <= count - 10'h001;
                  end else if (next_found) begin
                     state    <= ST_SAMPLE;  // R21
                     cur_chan <= next_chan;
                     count    <= sh_load;
                  end else begin
                     state      <= ST_IDLE;  // R23
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               count <= 10'h000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cell strobes follow the sequencer state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_channel <= 3'h0;
         cell_sample  <= 1'b0;
         cell_convert <= 1'b0;
         dma_req      <= 1'b0;
      end else begin
         cell_channel <= cur_chan;
         cell_sample  <= (state == ST_SAMPLE) & ~soft_rst;
         cell_convert <= (state == ST_CONV) & ~soft_rst;
         dma_req      <= capture & ~soft_rst;  // request on each new result
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration, channel enables, interrupt mask and soft reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst             <= 1'b0;
         mode_config          <= `ASC_MR_RESET;
         channel_enable_state <= 8'h00;
         irq_mask_state       <= 32'h00000000;
      end else if (soft_rst) begin
         soft_rst             <= 1'b0;  // R25
         mode_config          <= `ASC_MR_RESET;
         channel_enable_state <= 8'h00;
         irq_mask_state       <= 32'h00000000;
      end else begin
         soft_rst <= wr && (paddr == `ASC_OFF_CONTROL) && pwdata[`ASC_CR_SOFT_RESET];  // R2
         if (wr && paddr == `ASC_OFF_MODE)
            mode_config <= pwdata & `ASC_MR_MASK;
         if (wr && paddr == `ASC_OFF_CHAN_SET)
            channel_enable_state <= channel_enable_state | pwdata[7:0];  // R10
         else if (wr && paddr == `ASC_OFF_CHAN_CLR)
            channel_enable_state <= channel_enable_state & ~pwdata[7:0];  // R11
         if (wr && paddr == `ASC_OFF_IRQ_SET)
            irq_mask_state <= irq_mask_state | (pwdata & 32'h000fffff);
         else if (wr && paddr == `ASC_OFF_IRQ_CLR)
            irq_mask_state <= irq_mask_state & ~pwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags: set wins over a read clear in the same cycle
   assign done_set = capture ? (8'h01 << cur_chan) : 8'h00;
   assign done_clr = ((rd && paddr == `ASC_OFF_LAST_RESULT) ? (8'h01 << last_chan) : 8'h00) |
                     ((rd && in_result) ? (8'h01 << result_idx) : 8'h00);
   // only bits that the snapshot showed are cleared by a status read
   assign ovr_clr  = (rd && paddr == `ASC_OFF_STATUS) ? prdata[`ASC_SR_OVR_LO +: 8] : 8'h00;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_done      <= 8'h00;
         channel_overrun   <= 8'h00;
         global_overrun    <= 1'b0;
         result_ready      <= 1'b0;
         last_result_value <= 10'h000;
         last_chan         <= 3'h0;
      end else if (soft_rst) begin
         channel_done      <= 8'h00;  // R25
         channel_overrun   <= 8'h00;
         global_overrun    <= 1'b0;
         result_ready      <= 1'b0;
         last_result_value <= 10'h000;
         last_chan         <= 3'h0;
      end else begin
         channel_done    <= (channel_done & ~done_clr) | done_set;  // R19
         channel_overrun <= (channel_overrun & ~ovr_clr) |
                            (done_set & channel_done & ~done_clr);  // R18 R24
         if (capture) begin
            result_ready      <= 1'b1;  // R17
            last_result_value <= new_result;  // R20
            last_chan         <= cur_chan;
         end else if (rd && paddr == `ASC_OFF_LAST_RESULT) begin
            result_ready <= 1'b0;
         end
         if (capture && result_ready && !(rd && paddr == `ASC_OFF_LAST_RESULT))
            global_overrun <= 1'b1;  // R16 R24
         else if (rd && paddr == `ASC_OFF_STATUS && prdata[`ASC_SR_GOVR])
            global_overrun <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel result storage, loaded only for the converted channel
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gen_result
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               channel_result[g] <= 10'h000;
            else if (soft_rst)
               channel_result[g] <= 10'h000;
            else if (capture && cur_chan == g)
               channel_result[g] <= new_result;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read mux; write-only registers and command bits read zero
   always @* begin
      rd_data = 32'h00000000;
      rd_err  = 1'b0;
      case (paddr)
         `ASC_OFF_CONTROL:     rd_data = 32'h00000000;  // R1 R2
         `ASC_OFF_MODE:        rd_data = mode_config;
         `ASC_OFF_CHAN_SET:    rd_data = 32'h00000000;  // R10
         `ASC_OFF_CHAN_CLR:    rd_data = 32'h00000000;  // R11
         `ASC_OFF_CHAN_STATE:  rd_data = {24'h000000, channel_enable_state};  // R12
         `ASC_OFF_STATUS:      rd_data = {12'h000, dma_sync, global_overrun, result_ready,
                                          channel_overrun, channel_done};  // R14 R15
         `ASC_OFF_LAST_RESULT: rd_data = {22'h00000, last_result_value};
         `ASC_OFF_IRQ_SET:     rd_data = 32'h00000000;
         `ASC_OFF_IRQ_CLR:     rd_data = 32'h00000000;
         `ASC_OFF_IRQ_MASK:    rd_data = irq_mask_state;
         `ASC_OFF_REVISION:    rd_data = `ASC_REVISION;
         default: begin
            if (in_result)
               rd_data = {22'h00000, channel_result[result_idx]};
            else
               rd_err = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer: data and ready registered in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel && !penable) begin
            prdata  <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= rd_err;
         end else if (!psel) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

endmodule

// ===== bench/asc_cell_model.sv
// stand-in for the analog cell: answers with a code built from the channel
// assumes the sequencer holds cell_channel steady while cell_convert is high
module asc_cell_model (
   input wire [2:0]   cell_channel,
   input wire         cell_convert,
   output logic [9:0] cell_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // valid code while converting, its inverse once the phase is over
   assign cell_data = cell_convert ? {cell_channel, 7'h15} : ~{cell_channel, 7'h15};
endmodule

// ===== bench/asc_top_props.sv
// checker of bus read values and converter phase order of the sequencer
// assumes it is bound to asc_top and sees only that module's ports
module asc_top_props (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        cell_power,
   input wire [2:0]  cell_channel,
   input wire        cell_sample,
   input wire        cell_convert
);
   timeunit 1ns;
   timeprecision 1ns;
   // a read access completing at this edge
   wire rd = psel && penable && pready && !pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   a_control_reads_zero:
   assert property (rd && paddr == 8'h00 |-> prdata == 32'h0) else $error("control read");
   a_set_reads_zero:
   assert property (rd && paddr == 8'h10 |-> prdata == 32'h0) else $error("enable set read");
   a_clear_reads_zero:
   assert property (rd && paddr == 8'h14 |-> prdata == 32'h0) else $error("enable clear read");
   a_state_width:
   assert property (rd && paddr == 8'h18 |-> prdata[31:8] == 24'h0) else $error("state width");
   a_last_width:
   assert property (rd && paddr == 8'h20 |-> prdata[31:10] == 22'h0) else $error("last width");
   a_sample_then_conv:
   assert property ($fell(cell_sample) |-> cell_convert) else $error("no conversion after hold");
   a_conv_after_sample:
   assert property ($rose(cell_convert) |-> $past(cell_sample)) else $error("conversion unheld");
   a_channel_steady:
   assert property (cell_convert && $past(cell_convert) |-> $stable(cell_channel))
      else $error("channel moved");
   a_power_in_use:
   assert property (cell_sample || cell_convert |-> cell_power) else $error("cell unpowered");
   // main scenarios reached
   cover property (rd && paddr == 8'h1c);
   cover property ($rose(cell_convert));
   cover property ($fell(cell_power));
endmodule

// ===== bench/asc_top_tb.sv
// self-checking bench of the converter sequencer: table of register
// accesses, then conversion, overrun, trigger, sleep and soft reset cases
module asc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, err, ext_trigger = 0, cell_clk, cell_power;
   logic        dma_buffer_full_in = 1, dma_receive_end_in = 1;
   logic        cell_sample, cell_convert, dma_req;
   logic [5:0]  timer_output_a = 6'h00;
   logic [2:0]  cell_channel, code;
   logic [9:0]  cell_data;
   int          fails = 0, num_checks = 0, cycles = 0, results = 0, base, shl = 0, cvl = 0, pwr;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, x; logic e;} asc_row_t;
   asc_row_t rows[14] = '{
      '{0, 8'h1c, 0, 32'h000c0000, 0}, '{0, 8'h04, 0, 0, 0}, '{1, 8'h04, '1, 0, 0},
      '{0, 8'h04, 0, 32'h0f7fff3f, 0}, '{1, 8'h10, 32'ha5, 0, 0}, '{0, 8'h18, 0, 32'ha5, 0},
      '{0, 8'h10, 0, 0, 0}, '{1, 8'h14, 32'h21, 0, 0}, '{1, 8'h00, 0, 0, 0},
      '{0, 8'h18, 0, 32'h84, 0}, '{0, 8'h14, 0, 0, 0}, '{0, 8'h30, 0, 0, 0},
      '{0, 8'h08, 0, 0, 1}, '{0, 8'h00, 0, 0, 0}};
   asc_top asc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .timer_output_a, .ext_trigger, .dma_buffer_full_in,
      .dma_receive_end_in, .cell_data, .cell_clk, .cell_power, .cell_channel,
      .cell_sample, .cell_convert, .dma_req);
   asc_cell_model asc_cell_model_i (.cell_channel, .cell_convert, .cell_data);
   ////////////////////////////////////////////////////////////////////////////
   // clock, timeout and counters of results and phase cycles
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (dma_req === 1'b1) results++;
      if (cell_sample === 1'b1) shl++;
      if (cell_convert === 1'b1) cvl++;
      if (cell_power === 1'b1) pwr++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, x, g);
      end
   endtask
   // one apb transfer: setup, then access held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // wait for n results under a bound
   task wait_n(input int n);
      int k;
      k = 0;
      while (results < base + n && k < 400) begin
         @(posedge pclk);
         k++;
      end
      repeat (4) @(posedge pclk);
   endtask
   task run;
      base = results;
      apb(1, 8'h00, 32'h2);
      wait_n(2);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int s0, c0, p0;
      repeat (2) @(posedge pclk);
      chk("cell clock", 32'h1, {31'h0, cell_clk});
      presetn <= 1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("read data", rows[i].x, rdata);
         chk("slave error", {31'h0, rows[i].e}, {31'h0, err});
      end
      // channels 2 and 7, hold 1, divider 1
      apb(1, 8'h04, 32'h01000100);
      s0 = shl;
      c0 = cvl;
      run();
      chk("hold cycles", 32'd16, shl - s0);
      chk("convert cycles", 32'd80, cvl - c0);
      apb(0, 8'h1c, 0); chk("status", 32'h000f0084, rdata);
      apb(0, 8'h1c, 0); chk("status", 32'h000d0084, rdata);
      apb(0, 8'h20, 0); chk("last", 32'h00000395, rdata);
      apb(0, 8'h38, 0); chk("result 2", 32'h00000115, rdata);
      apb(0, 8'h1c, 0); chk("status", 32'h000c0000, rdata);
      // low resolution, two sequences unread
      apb(1, 8'h04, 32'h01000010);
      run();
      run();
      apb(0, 8'h1c, 0); chk("status", 32'h000f8484, rdata);
      apb(0, 8'h20, 0); chk("last", 32'h000000e5, rdata);
      // every trigger code, then external with the enable off
      for (int c = 0; c < 9; c++) begin
         code = (c == 8) ? 3'h6 : c[2:0];
         apb(1, 8'h04, {24'h010000, 4'h0, code, c < 8});
         base = results;
         timer_output_a <= (c == 7) ? 6'h3f : (code < 6) ? 6'h01 << code : 6'h00;
         ext_trigger <= (code >= 6);
         wait_n(2);
         chk("triggered", (c < 7) ? 32'd2 : 32'd0, results - base);
         timer_output_a <= 6'h00;
         ext_trigger <= 0;
      end
      // sleep mode: cell off in idle and again after a sequence
      apb(1, 8'h04, 32'h00010020);
      repeat (2) @(posedge pclk);
      chk("power", 32'h0, {31'h0, cell_power});
      p0 = pwr;
      run();
      chk("powered", 32'd77, pwr - p0);
      chk("power", 32'h0, {31'h0, cell_power});
      // soft reset with the dma lines low
      dma_buffer_full_in <= 0;
      dma_receive_end_in <= 0;
      apb(1, 8'h00, 32'h3);
      apb(0, 8'h04, 0); chk("mode", 32'h0, rdata);
      apb(0, 8'h18, 0); chk("state", 32'h0, rdata);
      apb(0, 8'h1c, 0); chk("status", 32'h0, rdata);
      conclude();
   end
endmodule
bind asc_top asc_top_props asc_top_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .cell_power, .cell_channel, .cell_sample, .cell_convert);
